// file: include/gx_pkg.sv
package gx_pkg;

    // APB register map, byte addresses.
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_CLEAR  = 12'h004;
    localparam logic [11:0] OFS_ENABLE = 12'h008;
    localparam logic [11:0] OFS_PINS   = 12'h00C;
    localparam logic [11:0] OFS_OUTCFG = 12'h010;
    localparam logic [11:0] OFS_POLADR = 12'h014;

    // Status, clear and enable bit positions.
    localparam int EV_ALERT = 0;
    localparam int EV_WRITE = 1;
    localparam int EV_READ  = 2;
    localparam int EV_W     = 3;

    // Serial register pointer codes, pairs share pointer bits 2:1.
    localparam logic [1:0] PAIR_IN  = 2'h0;
    localparam logic [1:0] PAIR_OUT = 2'h1;
    localparam logic [1:0] PAIR_POL = 2'h2;
    localparam logic [1:0] PAIR_CFG = 2'h3;

    // Reset values.
    localparam logic [15:0] OUT_RST = 16'hFFFF;
    localparam logic [15:0] POL_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'hFFFF;
    localparam logic [3:0]  UPPER_ADDR_DEF = 4'h4;

    // Spike filter on the serial lines.
    localparam int CLK_NS   = 20;
    localparam int SPIKE_NS = 50;
    localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] PRIME_DONE = 2'h3;

    typedef enum logic [2:0] {
        GX_IDLE  = 3'b000,
        GX_ADDR  = 3'b001,
        GX_CMD   = 3'b010,
        GX_WDATA = 3'b011,
        GX_ACK   = 3'b100,
        GX_RDATA = 3'b101,
        GX_RACK  = 3'b110
    } gx_state_t;

    typedef struct packed {
        logic [1:0]      scl_s;
        logic [1:0]      sda_s;
        logic [15:0]     pin_s0;
        logic [15:0]     pin_s1;
        logic [2:0]      as0;
        logic [2:0]      as1;
        logic            scl_f;
        logic            sda_f;
        logic            scl_p;
        logic            sda_p;
        logic [1:0]      fc_scl;
        logic [1:0]      fc_sda;
        gx_state_t       st;
        gx_state_t       nxt;
        logic [3:0]      cnt;
        logic [7:0]      sh;
        logic            ack;
        logic [2:0]      ptr;
        logic            sda_oe;
        logic [15:0]     outr;
        logic [15:0]     pol;
        logic [15:0]     cfg;
        logic [15:0]     inr;
        logic [1:0]      prime;
        logic            alert;
        logic [EV_W-1:0] sts;
        logic [EV_W-1:0] ien;
        logic [31:0]     prdata;
    } gx_st_t;

    localparam gx_st_t GX_ST_RST = '{
        scl_s: 2'h3, sda_s: 2'h3, scl_f: 1'b1, sda_f: 1'b1,
        scl_p: 1'b1, sda_p: 1'b1, st: GX_IDLE, nxt: GX_IDLE,
        outr: OUT_RST, pol: POL_RST, cfg: CFG_RST, default: '0};

endpackage

// file: logic/gx_expander.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns

module gx_expander
    import gx_pkg::*;
#(
    parameter logic [3:0] UPPER_ADDR = UPPER_ADDR_DEF
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB register port.
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // Serial bus, open drain data line.
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Address select straps.
    input  wire logic        addr_select_0,
    input  wire logic        addr_select_1,
    input  wire logic        addr_select_2,
    // Port pins.
    input  wire logic [7:0]  port_lo_pin_i,
    output logic      [7:0]  port_lo_pin_o,
    output logic      [7:0]  port_lo_pin_oe,
    input  wire logic [7:0]  port_hi_pin_i,
    output logic      [7:0]  port_hi_pin_o,
    output logic      [7:0]  port_hi_pin_oe,
    // Open drain change alert, active low.
    output logic             alert_n_o,
    output logic             alert_n_oe
);

    gx_st_t q;
    gx_st_t d;

    // The filtered level only follows after FILT_CYC stable samples.
    function automatic logic [2:0] filt(input logic s, input logic f,
                                        input logic [1:0] c);
        logic [1:0] n;
        n = c + 2'h1;
        if (s == f) begin
            filt = {f, 2'h0};
        end else if (n == 2'(FILT_CYC)) begin
            filt = {s, 2'h0};
        end else begin
            filt = {f, n};
        end
    endfunction

    logic            rise;
    logic            fall;
    logic            start;
    logic            stop;
    logic            ld;
    logic [15:0]     pins;
    logic [15:0]     m;
    logic [15:0]     rv16;
    logic [6:0]      dev_addr;
    logic            mism;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;

    always_comb begin
        d     = q;
        ld    = 1'b0;
        ev    = '0;
        clr   = '0;
        rv16  = 16'h0000;
        pins  = q.pin_s1;
        m     = q.ptr[0] ? 16'hFF00 : 16'h00FF;

        // Two-stage synchronisers on the serial lines, the port pins and the address straps.
        d.scl_s  = {q.scl_s[0], scl_i};
        d.sda_s  = {q.sda_s[0], sda_i};
        d.pin_s0 = {port_hi_pin_i, port_lo_pin_i};
        d.pin_s1 = q.pin_s0;
        d.as0    = {addr_select_2, addr_select_1, addr_select_0};
        d.as1    = q.as0;

        {d.scl_f, d.fc_scl} = filt(q.scl_s[1], q.scl_f, q.fc_scl);
        {d.sda_f, d.fc_sda} = filt(q.sda_s[1], q.sda_f, q.fc_sda);
        d.scl_p = q.scl_f;
        d.sda_p = q.sda_f;

        rise  = q.scl_f & ~q.scl_p;
        fall  = ~q.scl_f & q.scl_p;
        start = q.scl_f & q.scl_p & q.sda_p & ~q.sda_f;
        stop  = q.scl_f & q.scl_p & ~q.sda_p & q.sda_f;

        dev_addr = {UPPER_ADDR, q.as1};

        case (q.ptr[2:1])
            PAIR_IN:  rv16 = pins ^ q.pol;
            PAIR_OUT: rv16 = q.outr;
            PAIR_POL: rv16 = q.pol;
            default:  rv16 = q.cfg;
        endcase

        case (q.st)
            GX_ADDR, GX_CMD, GX_WDATA: begin
                if (rise) begin
                    d.sh  = {q.sh[6:0], q.sda_f};
                    d.cnt = q.cnt + 4'h1;
                end
                if (fall && q.cnt == 4'h8) begin
                    d.cnt = 4'h0;
                    d.st  = GX_ACK;
                    d.sda_oe = 1'b1;
                    case (q.st)
                        GX_ADDR: begin
                            d.nxt = q.sh[0] ? GX_RDATA : GX_CMD;
                            if (q.sh[7:1] != dev_addr) begin
                                d.st     = GX_IDLE;
                                d.sda_oe = 1'b0;
                            end
                        end
                        GX_CMD: begin
                            d.ptr = q.sh[2:0];
                            d.nxt = GX_WDATA;
                        end
                        default: begin
                            case (q.ptr[2:1])
                                PAIR_OUT: d.outr =
                                    (q.outr & ~m) | ({2{q.sh}} & m);
                                PAIR_POL: d.pol =
                                    (q.pol & ~m) | ({2{q.sh}} & m);
                                PAIR_CFG: d.cfg =
                                    (q.cfg & ~m) | ({2{q.sh}} & m);
                                default: ;
                            endcase
                            d.ptr[0] = ~q.ptr[0];
                            d.nxt    = GX_WDATA;
                            ev[EV_WRITE] = 1'b1;
                        end
                    endcase
                end
            end
            GX_ACK: begin
                if (fall) begin
                    d.sda_oe = 1'b0;
                    d.cnt    = 4'h0;
                    d.st     = q.nxt;
                    ld       = (q.nxt == GX_RDATA);
                end
            end
            GX_RDATA: begin
                if (rise) begin
                    d.cnt = q.cnt + 4'h1;
                end
                if (fall) begin
                    if (q.cnt == 4'h8) begin
                        d.sda_oe = 1'b0;
                        d.cnt    = 4'h0;
                        d.st     = GX_RACK;
                    end else begin
                        d.sh     = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6];
                    end
                end
            end
            GX_RACK: begin
                if (rise) begin
                    d.ack = ~q.sda_f;
                end
                if (fall) begin
                    d.st = q.ack ? GX_RDATA : GX_IDLE;
                    ld   = q.ack;
                end
            end
            default: ;
        endcase

        if (ld) begin
            d.sh     = q.ptr[0] ? rv16[15:8] : rv16[7:0];
            d.sda_oe = q.ptr[0] ? ~rv16[15] : ~rv16[7];
            d.ptr[0] = ~q.ptr[0];
            if (q.ptr[2:1] == PAIR_IN) begin
                d.inr = (q.inr & ~m) | (pins & m);
                ev[EV_READ] = 1'b1;
            end
        end

        if (start) begin
            d.st     = GX_ADDR;
            d.cnt    = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st     = GX_IDLE;
            d.sda_oe = 1'b0;
        end

        // The latch is primed from the pins so reset raises no alert.
        if (q.prime != PRIME_DONE) begin
            d.prime = q.prime + 2'h1;
            d.inr   = pins;
        end

        mism    = (q.prime == PRIME_DONE) && (pins != q.inr);
        d.alert = mism;
        ev[EV_ALERT] = mism & ~q.alert;

        // APB access: read data is captured in the setup cycle.
        if (psel && !penable && !pwrite) begin
            if (paddr == OFS_STATUS) begin
                d.prdata = {29'h0, q.sts};
            end else if (paddr == OFS_ENABLE) begin
                d.prdata = {29'h0, q.ien};
            end else if (paddr == OFS_PINS) begin
                d.prdata = {q.inr, pins};
            end else if (paddr == OFS_OUTCFG) begin
                d.prdata = {q.cfg, q.outr};
            end else if (paddr == OFS_POLADR) begin
                d.prdata = {5'h0, q.ptr, 1'b0, dev_addr, q.pol};
            end else begin
                d.prdata = 32'h0;
            end
        end
        if (psel && penable && pwrite) begin
            if (paddr == OFS_CLEAR) begin
                clr = pwdata[EV_W-1:0];
            end else if (paddr == OFS_ENABLE) begin
                d.ien = pwdata[EV_W-1:0];
            end
        end
        // A new event wins over a clear in the same cycle.
        d.sts = (q.sts & ~clr) | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= GX_ST_RST;
        end else begin
            q <= d;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     !(paddr == OFS_STATUS || paddr == OFS_CLEAR ||
                       paddr == OFS_ENABLE || paddr == OFS_PINS ||
                       paddr == OFS_OUTCFG || paddr == OFS_POLADR);
    assign prdata  = q.prdata;
    assign irq     = |(q.sts & q.ien);

    assign sda_o  = 1'b0;
    assign sda_oe = q.sda_oe;

    assign port_lo_pin_o = q.outr[7:0];
    assign port_hi_pin_o = q.outr[15:8];
    // enables come straight from reset flops
    assign port_lo_pin_oe = ~q.cfg[7:0];
    assign port_hi_pin_oe = ~q.cfg[15:8];

    assign alert_n_o  = 1'b0;
    assign alert_n_oe = q.alert;

endmodule

// file: dv/gx_sva.sv
`timescale 1ns/1ns
module gx_sva
    import gx_pkg::*;
(
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // Register port.
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Open drain lines and pins.
    input wire logic        sda_o,
    input wire logic        alert_n_o,
    input wire logic        alert_n_oe,
    input wire logic [7:0]  port_lo_pin_o,
    input wire logic [7:0]  port_lo_pin_oe,
    input wire logic [7:0]  port_hi_pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_always: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (
        psel && penable && paddr > OFS_POLADR |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (
        psel && penable && paddr <= OFS_POLADR && paddr[1:0] == 2'h0
        |-> !pslverr)
        else $error("error on mapped access");
    a_rdata_hold: assert property (
        ##1 $changed(prdata) |-> $past(psel && !penable))
        else $error("read data moved outside setup");
    a_lines_drain: assert property (
        sda_o == 1'b0 && alert_n_o == 1'b0)
        else $error("open drain line driven high");
    a_pins_input: assert property ($rose(presetn) |->
        port_lo_pin_oe == 8'h00 && port_hi_pin_oe == 8'h00)
        else $error("pin driven after reset");
    a_out_default: assert property (
        $rose(presetn) |-> port_lo_pin_o == 8'hFF)
        else $error("output default wrong");
    a_alert_quiet: assert property (
        $rose(presetn) |-> !alert_n_oe [*3])
        else $error("alert right after reset");
endmodule

bind gx_expander gx_sva u_sva (.pclk, .presetn, .paddr, .psel,
    .penable, .prdata, .pready, .pslverr, .sda_o, .alert_n_o,
    .alert_n_oe, .port_lo_pin_o, .port_lo_pin_oe, .port_hi_pin_oe);

// file: dv/gx_i2c_mst.sv
`timescale 1ns/1ns
module gx_i2c_mst (
    // Link tick and wired data line.
    input  wire logic lclk,
    input  wire logic sda,
    // Clock out, and data pull-down while high.
    output logic      scl,
    output logic      sda_dn
);
    initial begin
        scl = 1'b1;
        sda_dn = 1'b0;
    end
    // bus rate limit
    // Sixteen ticks a bit keep the clock just under 400 kHz.
    task automatic w(input int n);
        repeat (4 * n) @(posedge lclk);
    endtask
    task automatic start();
        sda_dn <= 1'b0;
        w(2);
        scl <= 1'b1;
        w(2);
        sda_dn <= 1'b1;
        w(2);
        scl <= 1'b0;
    endtask
    task automatic stop();
        w(1);
        sda_dn <= 1'b1;
        w(1);
        scl <= 1'b1;
        w(2);
        sda_dn <= 1'b0;
        w(2);
    endtask
    // Sends d then a as ninth bit; returns what the line showed.
    task automatic xbyte(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic ak);
        logic [8:0] s;
        s = {d, a};
        for (int i = 8; i >= 0; i--) begin
            w(1);
            sda_dn <= !s[i];
            w(1);
            scl <= 1'b1;
            w(2);
            s[i] = sda;
            scl <= 1'b0;
        end
        q = s[8:1];
        ak = s[0];
    endtask
endmodule

// file: dv/test_gx_expander.sv
`timescale 1ns/1ns
module test_gx_expander
    import gx_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        lclk = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, scl, sda_dn, sda_o, sda_oe;
    logic        alert_n_o, alert_n_oe;
    logic [15:0] ext = 16'h1234;
    logic [15:0] po, poe;
    wire         sda = !(sda_dn || sda_oe);
    wire  [15:0] pin = (poe & po) | (~poe & ext);
    int          n_errors = 0;
    int          tests_run = 0;
    localparam logic [6:0] DEV = {UPPER_ADDR_DEF, 3'h5};

    always #10 pclk = !pclk;
    initial #3 forever #80 lclk = !lclk;

    gx_expander dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .irq, .scl_i(scl),
        .sda_i(sda), .sda_o, .sda_oe, .addr_select_0(1'b1),
        .addr_select_1(1'b0), .addr_select_2(1'b1),
        .port_lo_pin_i(pin[7:0]), .port_lo_pin_o(po[7:0]),
        .port_lo_pin_oe(poe[7:0]), .port_hi_pin_i(pin[15:8]),
        .port_hi_pin_o(po[15:8]), .port_hi_pin_oe(poe[15:8]),
        .alert_n_o, .alert_n_oe);
    gx_i2c_mst mst (.lclk, .sda, .scl, .sda_dn);

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        if (a > OFS_POLADR) chk({31'h0, pslverr}, 32'h1);
        if (a > OFS_POLADR) chk(q, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] p, input logic [7:0] a, b);
        logic [7:0] q;
        logic       k;
        mst.start();
        mst.xbyte({DEV, 1'b0}, 1'b1, q, k);
        mst.xbyte({5'h00, p}, 1'b1, q, k);
        mst.xbyte(a, 1'b1, q, k);
        mst.xbyte(b, 1'b1, q, k);
        chk(k, 1'b0);
        mst.stop();
    endtask
    task automatic rd(input logic [2:0] p, output logic [7:0] x, y);
        logic [7:0] q;
        logic       k;
        mst.start();
        mst.xbyte({DEV, 1'b0}, 1'b1, q, k);
        mst.xbyte({5'h00, p}, 1'b1, q, k);
        mst.start();
        mst.xbyte({DEV, 1'b1}, 1'b1, q, k);
        mst.xbyte(8'hFF, 1'b0, x, k);
        mst.xbyte(8'hFF, 1'b1, y, k);
        mst.stop();
    endtask

    initial begin
        logic [31:0] r;
        logic [7:0]  x, y;
        logic        k;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(poe, 16'h0000);
        apb(1'b0, OFS_OUTCFG, 32'h0, r);
        chk(r, 32'hFFFF_FFFF);
        for (int p = 2; p < 8; p += 2) begin
            rd(p[2:0], x, y);
            chk({x, y}, p == 4 ? 16'h0000 : 16'hFFFF);
        end
        wr(3'h7, 8'h0F, 8'hF0);
        chk(poe, 16'hF00F);
        wr(3'h2, 8'hA5, 8'h3C);
        chk(po, 16'h3CA5);
        rd(3'h3, x, y);
        chk({x, y}, 16'h3CA5);
        wr(3'h0, 8'h00, 8'h00);
        wr(3'h4, 8'hFF, 8'h00);
        rd(3'h0, x, y);
        chk({y, x}, 16'h32CA);
        apb(1'b1, OFS_ENABLE, 32'h1, r);
        apb(1'b1, OFS_CLEAR, 32'h7, r);
        ext <= 16'h1334;
        repeat (8) @(posedge pclk);
        chk({alert_n_oe, irq}, 2'h3);
        ext <= 16'h1234;
        repeat (8) @(posedge pclk);
        chk(alert_n_oe, 1'b0);
        apb(1'b1, OFS_ENABLE, 32'h0, r);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0, r);
        chk(r[0], 1'b1);
        apb(1'b1, OFS_CLEAR, 32'h1, r);
        apb(1'b0, OFS_STATUS, 32'h0, r);
        chk(r[0], 1'b0);
        ext <= 16'h1334;
        repeat (8) @(posedge pclk);
        chk(alert_n_oe, 1'b1);
        rd(3'h1, x, y);
        chk(alert_n_oe, 1'b0);
        apb(1'b0, 12'h018, 32'h0, r);
        for (int a = 0; a < 8; a++) begin
            mst.start();
            mst.xbyte({UPPER_ADDR_DEF, a[2:0], 1'b0}, 1'b1, x, k);
            chk(k, a != 5);
            mst.stop();
        end
        close_out();
    end

    // Sized from the serial traffic above with some margin.
    initial begin
        repeat (95000) @(posedge pclk);
        n_errors++;
        close_out();
    end
endmodule
